// ---- core/gbc_pin_buck_ctl.sv ----
`timescale 1ns/1ps
// What this block does
// - Pin 2 source bits 7:6: 00 static, 01 fault, 11 sequencer, 10 reserved.
// - Pin 1 source bits 5:3: static, fault, sequencer, inputs 0/2/3 forwarded.
// - Pin 0 source bits 2:0: static, fault, sequencer, inputs 1/2/3 forwarded.
// - Pin 4 source bits 4:3: 00 static, 01 fault, 11 sequencer, 10 reserved.
// - Pin 3 source: static, fault, 32 kHz clock, sequencer, inputs 0/1/2.
// - Static source drives the mode bit; otherwise mode bit sets output polarity.
// - An input is active when its level equals its polarity bit.
// - Buck voltage source bits 6:5: sequencer or input pin 1, 2, 3.
// - Controlling input going active selects setting B, going passive setting A.
// - Buck enable source bits 2:1: sequencer or input pin 1, 2, 3.
// - Controlling input going active enables the buck, going passive disables it.
// - Buck bit 0 written 0 disables, 1 enables the regulator.
// - Bit 3 marks a buck sequenced, keeping it on in low-power hold.
module gbc_pin_buck_ctl
  import gbc_pkg::*;
#(
  parameter int NUM_PINS = 5,
  parameter int NUM_INPUTS = 4,
  parameter int NUM_BUCKS = 3
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Register access from the serial interface decoder.
  input wire gbc_wr_t regWr,
  input wire logic [ADDR_W-1:0] regRdAddr,
  output logic [7:0] regRdData_ff,
  // Pin configuration held elsewhere.
  input wire logic [NUM_PINS-1:0] pinLevelOrPolarity,
  input wire logic [NUM_INPUTS-1:0] pinActivePolarity,
  // Pin levels and internal sources.
  input wire logic [NUM_INPUTS-1:0] inputPinLevel,
  input wire logic supplyFaultFlag,
  input wire logic slowCrystalClock,
  input wire logic [NUM_PINS-1:0] seqPinActive,
  input wire logic lowPowerHoldState,
  // Sequencer requests, one per buck in order one, two, three.
  input wire gbc_seq_t [NUM_BUCKS-1:0] seqBuckReq,
  // Pin outputs.
  output logic [NUM_PINS-1:0] pinOut_ff,
  // Buck controls, order one, two, three.
  output logic [NUM_BUCKS-1:0] buckOn_ff,
  output logic [NUM_BUCKS-1:0] buckVoltSelB_ff,
  output logic [NUM_BUCKS-1:0] buckSequenced_ff
);

  logic [7:0] srcLow_ff;
  logic [7:0] nxt_srcLow;
  logic [7:0] srcHigh_ff;
  logic [7:0] nxt_srcHigh;
  logic [NUM_BUCKS-1:0][7:0] buckCtl_ff;
  logic [NUM_BUCKS-1:0][7:0] nxt_buckCtl;
  logic [NUM_INPUTS-1:0] inActive_ff;
  logic [NUM_INPUTS-1:0] nxt_inActive;
  logic [NUM_INPUTS-1:0] inRise;
  logic [NUM_INPUTS-1:0] inFall;
  logic [NUM_PINS-1:0] nxt_pinOut;
  logic [NUM_BUCKS-1:0] nxt_buckOn;
  logic [NUM_BUCKS-1:0] nxt_buckVoltSelB;
  logic [NUM_BUCKS-1:0] nxt_buckSequenced;
  logic [7:0] nxt_regRdData;
  logic [NUM_BUCKS-1:0] buckWrite;
  gbc_buck_t [NUM_BUCKS-1:0] buckState;
  gbc_src_t [NUM_PINS-1:0] pinSrc;

  // ==========================================================
  // Buck index to register offset.
  function automatic logic [ADDR_W-1:0] buckOffset(input int idx);
    case (idx)
      0: buckOffset = OFS_BUCK_ONE;
      1: buckOffset = OFS_BUCK_TWO;
      default: buckOffset = OFS_BUCK_THREE;
    endcase
  endfunction : buckOffset

  // ==========================================================
  // Source field decode per pin.
  function automatic gbc_src_t decodeSrc(input int pin, input logic [2:0] code);
    decodeSrc = SRC_RSVD;
    case (code)
      3'h0: decodeSrc = SRC_STATIC;
      3'h1: decodeSrc = SRC_FAULT;
      3'h2: decodeSrc = (pin == 3) ? SRC_CLK : SRC_RSVD;
      3'h3: decodeSrc = SRC_SEQ;
      3'h4:
      begin
        if (pin == 1 || pin == 3)
        begin
          decodeSrc = SRC_FWD0;
        end
      end
      3'h5:
      begin
        if (pin == 0 || pin == 3)
        begin
          decodeSrc = SRC_FWD1;
        end
      end
      3'h6:
      begin
        if (pin <= 3)
        begin
          decodeSrc = SRC_FWD2;
        end
      end
      3'h7:
      begin
        if (pin <= 1)
        begin
          decodeSrc = SRC_FWD3;
        end
      end
      default: decodeSrc = SRC_RSVD;
    endcase
  endfunction : decodeSrc

  // Two-bit fields of pins 2 and 4 use codes 0, 1 and 3 only.
  assign pinSrc[0] = decodeSrc(0, srcLow_ff[PIN0_SRC_LSB +: 3]);
  assign pinSrc[1] = decodeSrc(1, srcLow_ff[PIN1_SRC_LSB +: 3]);
  assign pinSrc[2] = decodeSrc(2, {1'b0, srcLow_ff[PIN2_SRC_LSB +: 2]});
  assign pinSrc[3] = decodeSrc(3, srcHigh_ff[PIN3_SRC_LSB +: 3]);
  assign pinSrc[4] = decodeSrc(4, {1'b0, srcHigh_ff[PIN4_SRC_LSB +: 2]});

  // ==========================================================
  // Input activity and transitions.
  always_comb
  begin
    nxt_inActive = ~(inputPinLevel ^ pinActivePolarity);
    inRise = nxt_inActive & ~inActive_ff;
    inFall = ~nxt_inActive & inActive_ff;
  end

  // ==========================================================
  // Pin output selection.
  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      logic act;
      act = 1'b0;
      case (pinSrc[p])
        SRC_FAULT: act = supplyFaultFlag;
        SRC_SEQ: act = seqPinActive[p];
        SRC_FWD0: act = inActive_ff[0];
        SRC_FWD1: act = inActive_ff[1];
        SRC_FWD2: act = inActive_ff[2];
        SRC_FWD3: act = inActive_ff[3];
        SRC_CLK: act = slowCrystalClock;
        default: act = 1'b0;
      endcase
      if (pinSrc[p] == SRC_STATIC)
      begin
        nxt_pinOut[p] = pinLevelOrPolarity[p];
      end
      else
      begin
        nxt_pinOut[p] = pinLevelOrPolarity[p] ? act : ~act;
      end
    end
  end

  // ==========================================================
  // Register writes and read back.
  always_comb
  begin
    nxt_srcLow = srcLow_ff;
    nxt_srcHigh = srcHigh_ff;
    nxt_buckCtl = buckCtl_ff;
    nxt_regRdData = 8'h00;
    if (regWr.en && regWr.addr == OFS_PIN_SRC_0_2)
    begin
      nxt_srcLow = regWr.data & MASK_PIN_SRC_0_2;
    end
    if (regWr.en && regWr.addr == OFS_PIN_SRC_3_4)
    begin
      nxt_srcHigh = regWr.data & MASK_PIN_SRC_3_4;
    end
    if (regRdAddr == OFS_PIN_SRC_0_2)
    begin
      nxt_regRdData = srcLow_ff;
    end
    if (regRdAddr == OFS_PIN_SRC_3_4)
    begin
      nxt_regRdData = srcHigh_ff;
    end
    for (int b = 0; b < NUM_BUCKS; b++)
    begin
      buckWrite[b] = regWr.en && regWr.addr == buckOffset(b);
      if (buckWrite[b])
      begin
        nxt_buckCtl[b] = regWr.data & MASK_BUCK;
      end
      if (regRdAddr == buckOffset(b))
      begin
        nxt_regRdData = buckCtl_ff[b];
        nxt_regRdData[BUCK_ON_BIT] = buckState[b].on;
      end
      nxt_buckOn[b] = buckState[b].on && !(lowPowerHoldState
        && !buckCtl_ff[b][BUCK_SEQ_FLAG_BIT]);
      nxt_buckVoltSelB[b] = buckState[b].voltSelB;
      nxt_buckSequenced[b] = buckCtl_ff[b][BUCK_SEQ_FLAG_BIT];
    end
  end

  // ==========================================================
  // Per-buck enable and voltage selection.
  generate
    for (genvar g = 0; g < NUM_BUCKS; g++)
    begin : gBuck
      gbc_buck_ctl uBuck (
        .clock(clock),
        .srst(srst),
        .ctrlByte(buckCtl_ff[g]),
        .onWrite(buckWrite[g]),
        .onWriteValue(regWr.data[BUCK_ON_BIT]),
        .inRise(inRise),
        .inFall(inFall),
        .seqReq(seqBuckReq[g]),
        .state(buckState[g])
      );
    end
  endgenerate

  // ==========================================================
  // Registers.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      srcLow_ff <= RESET_BYTE;
      srcHigh_ff <= RESET_BYTE;
      buckCtl_ff <= '0;
      inActive_ff <= '0;
      pinOut_ff <= '0;
      buckOn_ff <= '0;
      buckVoltSelB_ff <= '0;
      buckSequenced_ff <= '0;
      regRdData_ff <= 8'h00;
    end
    else
    begin
      srcLow_ff <= nxt_srcLow;
      srcHigh_ff <= nxt_srcHigh;
      buckCtl_ff <= nxt_buckCtl;
      inActive_ff <= nxt_inActive;
      pinOut_ff <= nxt_pinOut;
      buckOn_ff <= nxt_buckOn;
      buckVoltSelB_ff <= nxt_buckVoltSelB;
      buckSequenced_ff <= nxt_buckSequenced;
      regRdData_ff <= nxt_regRdData;
    end
  end

endmodule : gbc_pin_buck_ctl

// ---- core/gbc_pkg.sv ----
package gbc_pkg;

  // ==========================================================
  // Register map.
  localparam int ADDR_W = 9;
  localparam logic [8:0] OFS_PIN_SRC_0_2 = 9'h01e;
  localparam logic [8:0] OFS_PIN_SRC_3_4 = 9'h01f;
  localparam logic [8:0] OFS_BUCK_ONE = 9'h021;
  localparam logic [8:0] OFS_BUCK_THREE = 9'h022;
  localparam logic [8:0] OFS_BUCK_TWO = 9'h024;

  // ==========================================================
  // Field positions.
  localparam int PIN0_SRC_LSB = 0;
  localparam int PIN1_SRC_LSB = 3;
  localparam int PIN2_SRC_LSB = 6;
  localparam int PIN3_SRC_LSB = 0;
  localparam int PIN4_SRC_LSB = 3;
  localparam int BUCK_ON_BIT = 0;
  localparam int BUCK_EN_SRC_LSB = 1;
  localparam int BUCK_SEQ_FLAG_BIT = 3;
  localparam int BUCK_VOLT_SRC_LSB = 5;

  // Writable bits per register; the rest read as zero.
  localparam logic [7:0] MASK_PIN_SRC_0_2 = 8'hff;
  localparam logic [7:0] MASK_PIN_SRC_3_4 = 8'h1f;
  localparam logic [7:0] MASK_BUCK = 8'h6f;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Control-source code that hands a buck to the sequencer.
  localparam logic [1:0] CTRL_BY_SEQUENCER = 2'h0;

  // ==========================================================
  // Decoded output source of a pin.
  typedef enum logic [3:0] {
    SRC_STATIC = 4'h0,
    SRC_FAULT = 4'h1,
    SRC_SEQ = 4'h2,
    SRC_FWD0 = 4'h3,
    SRC_FWD1 = 4'h4,
    SRC_FWD2 = 4'h5,
    SRC_FWD3 = 4'h6,
    SRC_CLK = 4'h7,
    SRC_RSVD = 4'h8
  } gbc_src_t;

  // Register write request from the serial interface decoder.
  typedef struct packed {
    logic en;
    logic [8:0] addr;
    logic [7:0] data;
  } gbc_wr_t;

  // Sequencer requests for one buck.
  typedef struct packed {
    logic onSet;
    logic onClr;
    logic voltSelB;
  } gbc_seq_t;

  // State of one buck.
  typedef struct packed {
    logic on;
    logic voltSelB;
  } gbc_buck_t;

endpackage : gbc_pkg

// ---- core/gbc_buck_ctl.sv ----
`timescale 1ns/1ps
module gbc_buck_ctl
  import gbc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Control register and software write of the on bit.
  input wire logic [7:0] ctrlByte,
  input wire logic onWrite,
  input wire logic onWriteValue,
  // Input pin transitions, index 1 to 3 used.
  input wire logic [3:0] inRise,
  input wire logic [3:0] inFall,
  // Sequencer requests.
  input wire gbc_seq_t seqReq,
  // Buck state.
  output gbc_buck_t state
);

  logic on_ff;
  logic nxt_on;
  logic voltSelB_ff;
  logic nxt_voltSelB;
  logic [1:0] enSrc;
  logic [1:0] voltSrc;

  // ==========================================================
  // Next state.
  always_comb
  begin
    enSrc = ctrlByte[BUCK_EN_SRC_LSB +: 2];
    voltSrc = ctrlByte[BUCK_VOLT_SRC_LSB +: 2];
    nxt_on = on_ff;
    if (onWrite)
    begin
      nxt_on = onWriteValue;
    end
    if (enSrc == CTRL_BY_SEQUENCER)
    begin
      if (seqReq.onClr)
      begin
        nxt_on = 1'b0;
      end
      if (seqReq.onSet)
      begin
        nxt_on = 1'b1;
      end
    end
    else
    begin
      if (inFall[enSrc])
      begin
        nxt_on = 1'b0;
      end
      if (inRise[enSrc])
      begin
        nxt_on = 1'b1;
      end
    end
    nxt_voltSelB = voltSelB_ff;
    if (voltSrc == CTRL_BY_SEQUENCER)
    begin
      nxt_voltSelB = seqReq.voltSelB;
    end
    else if (inRise[voltSrc])
    begin
      nxt_voltSelB = 1'b1;
    end
    else if (inFall[voltSrc])
    begin
      nxt_voltSelB = 1'b0;
    end
  end

  // ==========================================================
  // State registers.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      on_ff <= 1'b0;
      voltSelB_ff <= 1'b0;
    end
    else
    begin
      on_ff <= nxt_on;
      voltSelB_ff <= nxt_voltSelB;
    end
  end

  assign state.on = on_ff;
  assign state.voltSelB = voltSelB_ff;

endmodule : gbc_buck_ctl

// ---- bench/gbc_pin_buck_ctl_assertions.sv ----
`timescale 1ns/1ps
module gbc_pin_buck_ctl_assertions
  import gbc_pkg::*;
#(
  parameter int NUM_PINS = 5,
  parameter int NUM_INPUTS = 4,
  parameter int NUM_BUCKS = 3
)
(
  // Clock, reset and register access.
  input wire logic clock,
  input wire logic srst,
  input wire gbc_wr_t regWr,
  input wire logic [ADDR_W-1:0] regRdAddr,
  input wire logic [7:0] regRdData_ff,
  // Pin inputs.
  input wire logic [NUM_PINS-1:0] pinLevelOrPolarity,
  input wire logic [NUM_INPUTS-1:0] pinActivePolarity,
  input wire logic [NUM_INPUTS-1:0] inputPinLevel,
  input wire logic supplyFaultFlag,
  input wire logic slowCrystalClock,
  input wire logic [NUM_PINS-1:0] seqPinActive,
  input wire logic lowPowerHoldState,
  // Outputs.
  input wire logic [NUM_PINS-1:0] pinOut_ff,
  input wire logic [NUM_BUCKS-1:0] buckOn_ff,
  input wire logic [NUM_BUCKS-1:0] buckSequenced_ff
);
  // ==========================================================
  // Mirror of the source registers.
  logic [7:0] src02_ff;
  logic [7:0] src34_ff;
  logic live_ff;
  always_ff @(posedge clock)
  begin
    live_ff <= !srst;
    if (srst)
      src02_ff <= 8'h00;
    else if (regWr.en && regWr.addr == OFS_PIN_SRC_0_2)
      src02_ff <= regWr.data;
    if (srst)
      src34_ff <= 8'h00;
    else if (regWr.en && regWr.addr == OFS_PIN_SRC_3_4)
      src34_ff <= regWr.data;
  end

  // ==========================================================
  // Assertions.
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sequence fwdSteady;
    live_ff && src02_ff[2:0] == 3'h5 && $stable(pinActivePolarity)
      && $stable(pinLevelOrPolarity);
  endsequence

  chk_pin0_fault: assert property (live_ff && src02_ff[2:0] == 3'h1 |=>
    pinOut_ff[0] == ($past(supplyFaultFlag) ~^ $past(pinLevelOrPolarity[0])))
    else $error("pin 0 does not follow the fault flag");
  chk_pin2_seq: assert property (live_ff && src02_ff[7:6] == 2'h3 |=>
    pinOut_ff[2] == ($past(seqPinActive[2]) ~^ $past(pinLevelOrPolarity[2])))
    else $error("pin 2 does not follow the sequencer");
  chk_pin3_clock: assert property (live_ff && src34_ff[2:0] == 3'h2 |=>
    pinOut_ff[3] == ($past(slowCrystalClock) ~^ $past(pinLevelOrPolarity[3])))
    else $error("pin 3 does not follow the slow clock");
  chk_pin4_static: assert property (live_ff && src34_ff[4:3] == 2'h0 |=>
    pinOut_ff[4] == $past(pinLevelOrPolarity[4]))
    else $error("pin 4 does not show its static level");
  chk_pin1_reserved: assert property (live_ff && src02_ff[5:3] inside {3'h2, 3'h5} |=>
    pinOut_ff[1] == !$past(pinLevelOrPolarity[1]))
    else $error("pin 1 not inactive on a reserved code");
  chk_pin0_forward: assert property (fwdSteady ##1 fwdSteady |=>
    pinOut_ff[0] == (($past(inputPinLevel[1], 2) ~^ $past(pinActivePolarity[1], 2))
    ~^ $past(pinLevelOrPolarity[0])))
    else $error("pin 0 does not forward input one");
  chk_rsvd_bits: assert property (regRdAddr == OFS_PIN_SRC_3_4 |=> regRdData_ff[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  chk_hold_off: assert property (lowPowerHoldState |=>
    buckSequenced_ff[0] || !buckOn_ff[0])
    else $error("buck one on in low power hold");
endmodule : gbc_pin_buck_ctl_assertions

bind gbc_pin_buck_ctl gbc_pin_buck_ctl_assertions #(.NUM_PINS(NUM_PINS),
  .NUM_INPUTS(NUM_INPUTS), .NUM_BUCKS(NUM_BUCKS)) gbc_pin_buck_ctl_assertions_inst (
  .clock(clock), .srst(srst), .regWr(regWr), .regRdAddr(regRdAddr),
  .regRdData_ff(regRdData_ff), .pinLevelOrPolarity(pinLevelOrPolarity),
  .pinActivePolarity(pinActivePolarity), .inputPinLevel(inputPinLevel),
  .supplyFaultFlag(supplyFaultFlag), .slowCrystalClock(slowCrystalClock),
  .seqPinActive(seqPinActive), .lowPowerHoldState(lowPowerHoldState),
  .pinOut_ff(pinOut_ff), .buckOn_ff(buckOn_ff), .buckSequenced_ff(buckSequenced_ff));

// ---- bench/gbc_host_model.sv ----
`timescale 1ns/1ps
module gbc_host_model
  import gbc_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Register access.
  output gbc_wr_t regWr,
  output logic [8:0] regRdAddr,
  input wire logic [7:0] regRdData_ff
);
  initial
  begin
    regWr = '0;
    regRdAddr = 9'h000;
  end

  // Idle cycles carry inverted data so stale bytes are never mistaken for a write.
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clock);
    regWr = '{en: 1'b1, addr: a, data: d};
    @(negedge clock);
    regWr = '{en: 1'b0, addr: a, data: ~d};
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge clock);
    regRdAddr = a;
    @(negedge clock);
    d = regRdData_ff;
  endtask : rd
endmodule : gbc_host_model

// ---- bench/test_gbc_pin_buck_ctl.sv ----
`timescale 1ns/1ps
module test_gbc_pin_buck_ctl
  import gbc_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  gbc_wr_t regWr;
  logic [8:0] regRdAddr;
  logic [7:0] rdData, rv, tmp;
  logic [4:0] md, sq, pinOut;
  logic [3:0] ty, lv;
  logic flt, sck, hold;
  logic [2:0] c, k, bOn, bVolt, bSeq;
  gbc_seq_t [2:0] sb;
  int badCount = 0;
  int nChecks = 0;
  logic [8:0] ad [6] = '{OFS_PIN_SRC_0_2, OFS_PIN_SRC_3_4, OFS_BUCK_ONE, OFS_BUCK_TWO,
    OFS_BUCK_THREE, 9'h1a0};
  logic [7:0] mk [6] = '{MASK_PIN_SRC_0_2, MASK_PIN_SRC_3_4, MASK_BUCK, MASK_BUCK,
    MASK_BUCK, 8'h00};

  always #4 clock = ~clock;

  gbc_pin_buck_ctl gbc_pin_buck_ctl_inst (.clock(clock), .srst(srst), .regWr(regWr),
    .regRdAddr(regRdAddr), .regRdData_ff(rdData), .pinLevelOrPolarity(md),
    .pinActivePolarity(ty), .inputPinLevel(lv), .supplyFaultFlag(flt),
    .slowCrystalClock(sck), .seqPinActive(sq), .lowPowerHoldState(hold),
    .seqBuckReq(sb), .pinOut_ff(pinOut), .buckOn_ff(bOn), .buckVoltSelB_ff(bVolt),
    .buckSequenced_ff(bSeq));
  gbc_host_model gbc_host_model_inst (.clock(clock), .regWr(regWr),
    .regRdAddr(regRdAddr), .regRdData_ff(rdData));

  // ==========================================================
  // Helpers.
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic completeRun;
    if (badCount == 0 && nChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : completeRun

  function automatic logic pexp(input int p, input logic [2:0] k);
    logic a;
    logic r;
    r = (k == 3'h2 && p != 3) || (p == 0 && k == 3'h4);
    r = r || (p == 1 && k == 3'h5) || (p == 3 && k == 3'h7);
    case (k)
      3'h0: a = md[p];
      3'h1: a = flt;
      3'h2: a = sck;
      3'h3: a = sq[p];
      default: a = lv[k - 3'h4] ~^ ty[k - 3'h4];
    endcase
    return r ? !md[p] : (k == 3'h0 ? a : (a ~^ md[p]));
  endfunction : pexp

  initial
  begin
    #100000;
    badCount++;
    completeRun();
  end

  // ==========================================================
  // Main sequence.
  initial
  begin
    {md, sq, ty, lv, flt, sck, hold, sb} = '0;
    tmp = 8'($urandom(32'hafcc));
    cyc(10);
    srst = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      gbc_host_model_inst.rd(ad[i], rv);
      chk("reset value", rv, 8'h00);
      tmp = 8'($urandom);
      gbc_host_model_inst.wr(ad[i], tmp);
      gbc_host_model_inst.rd(ad[i], rv);
      chk("readback", rv, tmp & mk[i]);
    end
    for (int i = 0; i < 40; i++)
    begin
      c = (i < 8) ? 3'(i) : 3'($urandom);
      {md, sq, ty, lv, flt, sck} = 20'($urandom);
      gbc_host_model_inst.wr(OFS_PIN_SRC_0_2, {c[1:0], c, c});
      gbc_host_model_inst.wr(OFS_PIN_SRC_3_4, {3'h0, c[1:0], c});
      cyc(3);
      for (int p = 0; p < 5; p++)
      begin
        k = (p == 2 || p == 4) ? {1'b0, c[1:0]} : c;
        chk("pin", 8'(pinOut[p]), 8'(pexp(p, k)));
      end
    end
    for (int b = 0; b < 3; b++)
    begin
      for (int s = 1; s < 4; s++)
      begin
        ty = 4'($urandom);
        lv = ~ty;
        gbc_host_model_inst.wr(ad[b + 2], {1'b0, 2'(s), 2'h0, 2'(s), 1'b0});
        cyc(3);
        lv[s] = ty[s];
        cyc(4);
        chk("buck on", 8'(bOn[b]), 8'h01);
        chk("buck volt", 8'(bVolt[b]), 8'h01);
        lv[s] = ~ty[s];
        lv[s % 3 + 1] = ty[s % 3 + 1];
        cyc(4);
        chk("buck off", 8'(bOn[b]), 8'h00);
        chk("buck volt a", 8'(bVolt[b]), 8'h00);
      end
      gbc_host_model_inst.wr(ad[b + 2], 8'h00);
      sb[b] = '{onSet: 1'b1, onClr: 1'b0, voltSelB: 1'b1};
      cyc(1);
      sb[b].onSet = 1'b0;
      cyc(3);
      chk("seq on", 8'({bOn[b], bVolt[b]}), 8'h03);
      sb[b] = '{onSet: 1'b0, onClr: 1'b1, voltSelB: 1'b0};
      cyc(1);
      sb[b].onClr = 1'b0;
      cyc(3);
      chk("seq off", 8'({bOn[b], bVolt[b]}), 8'h00);
      gbc_host_model_inst.wr(ad[b + 2], 8'h01);
      cyc(3);
      chk("sw on", 8'(bOn[b]), 8'h01);
      hold = 1'b1;
      cyc(3);
      chk("hold off", 8'(bOn[b]), 8'h00);
      gbc_host_model_inst.wr(ad[b + 2], 8'h09);
      cyc(3);
      chk("hold kept", 8'({bOn[b], bSeq[b]}), 8'h03);
      hold = 1'b0;
      gbc_host_model_inst.wr(ad[b + 2], 8'h00);
      cyc(3);
      chk("sw off", 8'(bOn[b]), 8'h00);
    end
    completeRun();
  end
endmodule : test_gbc_pin_buck_ctl
